//--- hw/cip_params.svh
// constants for the core interrupt prioritizer
// assumes inclusion by cip_pkg, the top module and the testbench
`ifndef CIP_PARAMS_SVH
`define CIP_PARAMS_SVH
`define CIP_ADDR_CTRL      8'h00
`define CIP_ADDR_STATUS0   8'h04
`define CIP_ADDR_LVL_MASK  8'h08
`define CIP_ADDR_PEND      8'h0C
`define CIP_ADDR_SRC_FLAG  8'h10
`define CIP_ADDR_SRC_MASK  8'h14
`define CIP_ADDR_SW_REQ    8'h18
`define CIP_ADDR_ACK_INFO  8'h1C
`define CIP_ADDR_PERIPH_VEC 8'h20
`define CIP_ADDR_STACK_TOP 8'h24
`define CIP_ADDR_PC        8'h28
`define CIP_GID_BIT        9
`define CIP_CTRL_NMI_POL   0
`define CIP_SWREQ_VEC_CALL 31
`define CIP_SWREQ_TRAP     30
`define CIP_SWREQ_NMI      29
`define CIP_VEC_NMI        6'h24
`define CIP_VEC_TRAP       6'h22
`define CIP_PHANTOM_OFS    6'h00
`define CIP_RESP_OKAY      2'h0
`define CIP_RESP_SLVERR    2'h2
`define CIP_N_LEVELS       6
`define CIP_N_SRC          7
`define CIP_STACK_DEPTH    8
`endif

//--- hw/cip_pkg.sv
// types shared by the core interrupt prioritizer
// assumes cip_params.svh is on the include path
`include "cip_params.svh"
package cip_pkg;
  typedef enum logic [1:0] {
    CIP_IDLE,
    CIP_FETCH,
    CIP_RUN
  } cip_state_e;
  typedef struct packed {
    logic       valid;
    logic [5:0] vector;
    logic [3:0] rank;
    logic       sets_gid;
  } cip_ack_s;
endpackage

//--- hw/cip_top.sv
// core interrupt prioritizer: intake, ranking, acknowledge, stack and return
// assumes i_src_irq / i_nmi_pin / i_lvl_irq come from pins or other domains
// What this block does
// - nmi alters no mode, aborts nothing
// - nmi ignores global disable, has no mask
// - nmi blocked during nmi or reset; an edge in a fetch cycle is lost
// - nmi vectors to 24h, sets global disable
// - nmi pin polarity programmable, resets active high
// - vector call uses operand, sets disable
// - trap vectors 22h, disable unchanged
// - emulator trap via vector call or trap
// - ack pushes pc unless stack full, loads vector, fetches branch
// - any hw or call/nmi ack sets disable
// - return pops stack into program counter
// - vector slots two words apart
// - lines ranked 1..10, highest first
// - reset, resv, nmi, levels one-six, resv
// - six shared maskable core levels
// - level one shared by seven sources
// - levels 1,5,6,nmi system; 2-4 event
// - each source sets its own flag
// - flagged source forwarded only when unmasked
// - arbitration sets pending level flag
// - ack needs level mask and disable clear
// - reset clears pending, masks; sets disable
// - global disable is status bit 9
// - phantom offset when no source requests
`include "cip_params.svh"
module cip_top
  import cip_pkg::*;
#(
  parameter int N_LEVELS    = `CIP_N_LEVELS,
  parameter int N_SRC       = `CIP_N_SRC,
  parameter int STACK_DEPTH = `CIP_STACK_DEPTH
) (
  input  wire logic                I_CORE_CLK,
  input  wire logic                I_RST,
  input  wire logic                i_ext_reset_pin_n,
  input  wire logic                i_power_on_reset_pin_n,
  input  wire logic                i_nmi_pin,
  input  wire logic [N_SRC-1:0]    i_src_irq,
  input  wire logic [N_LEVELS-1:0] i_lvl_irq,
  input  wire logic                i_ret,
  input  wire logic [15:0]         i_ret_pc,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [7:0]          s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     o_ack,
  output logic [5:0]               o_ack_vector,
  output logic                     o_fetch,
  output logic [15:0]              o_pc,
  output logic                     o_global_irq_disable
);
  initial begin
    if (N_LEVELS != `CIP_N_LEVELS || N_SRC < 1 || N_SRC > 16 || STACK_DEPTH < 2
        || STACK_DEPTH > 16) begin
      $error("cip_top: unsupported parameters");
    end
  end

  localparam int SPW = $clog2(STACK_DEPTH);
  // reset pins idle high: syncs start there so a release shows no false reset
  localparam logic [N_SRC+N_LEVELS+2:0] PIN_IDLE = {2'h3, {(N_SRC+N_LEVELS+1){1'b0}}};

  // pin inputs: three stages, change accepted once stages two and three agree
  logic [N_SRC+N_LEVELS+2:0] sy1_q, sy2_q, sy3_q, pin_q, pin_d;
  logic [N_SRC+N_LEVELS+2:0] raw;
  assign raw = {i_ext_reset_pin_n, i_power_on_reset_pin_n, i_nmi_pin, i_lvl_irq, i_src_irq};
  always_comb begin
    pin_d = pin_q;
    for (int i = 0; i <= N_SRC+N_LEVELS+2; i++) begin
      if (sy2_q[i] == sy3_q[i]) begin
        pin_d[i] = sy3_q[i];
      end
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sy1_q <= PIN_IDLE;
      sy2_q <= PIN_IDLE;
      sy3_q <= PIN_IDLE;
      pin_q <= PIN_IDLE;
    end else begin
      sy1_q <= raw;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pin_q <= pin_d;
    end
  end
  logic [N_SRC-1:0]    src_lvl;
  logic [N_LEVELS-1:0] lvl_lvl;
  logic                nmi_raw, rst_any;
  assign src_lvl = pin_q[N_SRC-1:0];
  assign lvl_lvl = pin_q[N_SRC+N_LEVELS-1:N_SRC];
  assign nmi_raw = pin_q[N_SRC+N_LEVELS];
  // both reset pins fixed active low
  assign rst_any = I_RST | ~pin_q[N_SRC+N_LEVELS+1] | ~pin_q[N_SRC+N_LEVELS+2];

  // register and control state
  logic [31:0]         ctrl_q, ctrl_d;
  logic                gid_q, gid_d;
  logic [N_LEVELS-1:0] lmask_q, lmask_d, pend_q, pend_d;
  logic [N_SRC-1:0]    sflag_q, sflag_d, smask_q, smask_d, src_prev_q;
  logic                nmi_prev_q, nmi_busy_q, nmi_busy_d;
  logic [31:0]         swreq_q, swreq_d;
  cip_ack_s            last_q, last_d;
  logic [5:0]          pvec_q, pvec_d;
  logic [15:0]         pc_q, pc_d;
  logic [15:0]         stk_q [STACK_DEPTH];
  logic [15:0]         stk_d [STACK_DEPTH];
  logic [SPW:0]        sp_q, sp_d;
  cip_state_e          st_q, st_d;
  logic                ack_q, ack_d, fetch_q, fetch_d;
  logic [5:0]          ackv_q, ackv_d;
  logic                nmi_type_q, nmi_type_d;

  // axi-lite slave: single outstanding write and read
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, ar_q, ar_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d, ara_q, ara_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [3:0]  ws_q, ws_d;
  logic        wr_go, rd_go;
  assign wr_go = aw_q & w_q & ~bv_q;
  assign rd_go = ar_q & ~rv_q;

  // nmi pin with programmable polarity
  logic nmi_pin_act, nmi_edge, nmi_req;
  assign nmi_pin_act = nmi_raw ^ ctrl_q[`CIP_CTRL_NMI_POL];
  assign nmi_edge    = nmi_pin_act & ~nmi_prev_q;
  logic sw_call, sw_trap, sw_nmi;
  assign sw_call = swreq_q[`CIP_SWREQ_VEC_CALL];
  assign sw_trap = swreq_q[`CIP_SWREQ_TRAP];
  assign sw_nmi  = swreq_q[`CIP_SWREQ_NMI];
  // no mask, no global disable; locked by nmi service or reset, lost in a fetch cycle
  assign nmi_req = (nmi_edge | sw_nmi) & ~nmi_busy_q;

  // source flags gated by own masks, lowest index ranks highest
  logic [N_SRC-1:0] src_fwd;
  assign src_fwd = sflag_q & smask_q;
  logic [N_LEVELS-1:0] lvl_take;
  // level one: arbitrated local sources; others straight from the event
  // manager and system module lines
  assign lvl_take = {lvl_lvl[N_LEVELS-1:1], |src_fwd};
  logic [N_LEVELS-1:0] lvl_ok;
  // level needs its mask bit and global disable clear
  assign lvl_ok = pend_q & lmask_q & {N_LEVELS{~gid_q}};

  always_comb begin
    ctrl_d = ctrl_q;
    gid_d = gid_q;
    lmask_d = lmask_q;
    pend_d = pend_q;
    sflag_d = sflag_q;
    smask_d = smask_q;
    swreq_d = '0;
    last_d = last_q;
    pvec_d = pvec_q;
    pc_d = pc_q;
    sp_d = sp_q;
    stk_d = stk_q;
    st_d = st_q;
    ack_d = 1'b0;
    fetch_d = 1'b0;
    ackv_d = ackv_q;
    nmi_busy_d = nmi_busy_q;
    nmi_type_d = nmi_type_q;
    aw_d = aw_q | s_axi_awvalid;
    w_d = w_q | s_axi_wvalid;
    awa_d = aw_q ? awa_q : s_axi_awaddr;
    wd_d = w_q ? wd_q : s_axi_wdata;
    ws_d = w_q ? ws_q : s_axi_wstrb;
    bv_d = bv_q & ~s_axi_bready;
    br_d = br_q;
    ar_d = ar_q | s_axi_arvalid;
    ara_d = ar_q ? ara_q : s_axi_araddr;
    rv_d = rv_q & ~s_axi_rready;
    rd_d = rd_q;
    rr_d = rr_q;

    // software writes; hardware sets below win over clears
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = `CIP_RESP_OKAY;
      case (awa_q)
        `CIP_ADDR_CTRL: if (ws_q[0]) ctrl_d[7:0] = wd_q[7:0];
        `CIP_ADDR_STATUS0: if (ws_q[1]) gid_d = wd_q[`CIP_GID_BIT];
        `CIP_ADDR_LVL_MASK: lmask_d = wd_q[N_LEVELS-1:0];
        `CIP_ADDR_PEND: pend_d = pend_q & ~wd_q[N_LEVELS-1:0];
        `CIP_ADDR_SRC_FLAG: sflag_d = sflag_q & ~wd_q[N_SRC-1:0];
        `CIP_ADDR_SRC_MASK: smask_d = wd_q[N_SRC-1:0];
        `CIP_ADDR_SW_REQ: swreq_d = wd_q;
        default: br_d = `CIP_RESP_SLVERR;
      endcase
    end

    // per-source flag on rising request
    sflag_d = sflag_d | (src_lvl & ~src_prev_q);
    // arbitration winner sets pending level
    pend_d = pend_d | lvl_take;

    if (rd_go) begin
      ar_d = 1'b0;
      rv_d = 1'b1;
      rr_d = `CIP_RESP_OKAY;
      rd_d = '0;
      case (ara_q)
        `CIP_ADDR_CTRL: rd_d = ctrl_q;
        `CIP_ADDR_STATUS0: rd_d[`CIP_GID_BIT] = gid_q;
        `CIP_ADDR_LVL_MASK: rd_d[N_LEVELS-1:0] = lmask_q;
        `CIP_ADDR_PEND: rd_d[N_LEVELS-1:0] = pend_q;
        `CIP_ADDR_SRC_FLAG: rd_d[N_SRC-1:0] = sflag_q;
        `CIP_ADDR_SRC_MASK: rd_d[N_SRC-1:0] = smask_q;
        `CIP_ADDR_ACK_INFO: rd_d[11:0] = {last_q.sets_gid, last_q.rank, last_q.vector, last_q.valid};
        `CIP_ADDR_PERIPH_VEC: begin
          // reading the vector resets it to the phantom offset
          rd_d[5:0] = pvec_q;
          pvec_d = `CIP_PHANTOM_OFS;
        end
        `CIP_ADDR_STACK_TOP: rd_d[15:0] = (sp_q != '0) ? stk_q[sp_q[SPW-1:0]-1'b1] : 16'h0000;
        `CIP_ADDR_PC: rd_d[15:0] = pc_q;
        default: rr_d = `CIP_RESP_SLVERR;
      endcase
    end

    // acknowledge engine; nmi does not wait for the current routine
    if (st_q == CIP_FETCH) begin
      // fetch the branch held at the vector slot
      fetch_d = 1'b1;
      pc_d = pc_q + 16'h0002; // two-word branch per slot
      st_d = CIP_RUN;
    end else begin
      // fixed core ranking: nmi 3, levels 4..9 in order
      logic took;
      logic [5:0] vec;
      logic [3:0] rk;
      logic setg;
      took = 1'b0;
      vec = 6'h00;
      rk = 4'h0;
      setg = 1'b1;
      if (nmi_req) begin
        took = 1'b1;
        vec = `CIP_VEC_NMI;
        rk = 4'h3;
        nmi_busy_d = 1'b1;
      end else if (sw_call) begin
        // operand picks any vector incl. user and emulator trap
        took = 1'b1;
        vec = {swreq_q[4:0], 1'b0};
        rk = 4'h0;
      end else if (sw_trap) begin
        took = 1'b1;
        vec = `CIP_VEC_TRAP;
        setg = 1'b0;
      end else if (|lvl_ok) begin
        for (int l = N_LEVELS-1; l >= 0; l--) begin
          if (lvl_ok[l]) begin
            vec = 6'((l + 1) * 2);
            rk = 4'(l + 4);
          end
        end
        took = 1'b1;
        for (int l = 0; l < N_LEVELS; l++) begin
          if (lvl_ok[l] && rk == 4'(l + 4)) begin
            pend_d[l] = 1'b0;
          end
        end
        if (rk == 4'h4) begin
          // peripheral offset of highest flagged source or phantom
          pvec_d = `CIP_PHANTOM_OFS;
          for (int s = N_SRC-1; s >= 0; s--) begin
            if (src_fwd[s]) pvec_d = 6'(s + 1);
          end
          for (int s = 0; s < N_SRC; s++) begin
            // a fresh edge in the ack cycle keeps its flag
            if (src_fwd[s] && pvec_d == 6'(s + 1)) sflag_d[s] = src_lvl[s] & ~src_prev_q[s];
          end
        end
      end
      if (took) begin
        // push return pc, load vector address
        if (sp_q != STACK_DEPTH[SPW:0]) begin
          stk_d[sp_q[SPW-1:0]] = pc_q;
          sp_d = sp_q + 1'b1;
        end
        pc_d = {10'h000, vec};
        if (setg) gid_d = 1'b1;
        ack_d = 1'b1;
        ackv_d = vec;
        nmi_type_d = (vec == `CIP_VEC_NMI);
        last_d = '{valid: 1'b1, vector: vec, rank: rk, sets_gid: setg};
        st_d = CIP_FETCH;
      end else if (i_ret && sp_q != '0) begin
        // pop return address into pc
        pc_d = stk_q[sp_q[SPW-1:0]-1'b1];
        sp_d = sp_q - 1'b1;
        if (nmi_type_q) nmi_busy_d = 1'b0;
        nmi_type_d = 1'b0;
        st_d = CIP_IDLE;
      end else if (st_q == CIP_RUN) begin
        pc_d = i_ret_pc;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (rst_any) begin
      // reset state: pending and masks clear, global disable set
      ctrl_q <= '0;
      gid_q <= 1'b1;
      lmask_q <= '0;
      pend_q <= '0;
      sflag_q <= '0;
      smask_q <= '0;
      swreq_q <= '0;
      last_q <= '0;
      pvec_q <= `CIP_PHANTOM_OFS;
      pc_q <= 16'h0000;
      sp_q <= '0;
      for (int k = 0; k < STACK_DEPTH; k++) stk_q[k] <= 16'h0000;
      st_q <= CIP_IDLE;
      ack_q <= 1'b0;
      fetch_q <= 1'b0;
      ackv_q <= 6'h00;
      nmi_busy_q <= 1'b0;
      nmi_type_q <= 1'b0;
      nmi_prev_q <= 1'b0;
      src_prev_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      gid_q <= gid_d;
      lmask_q <= lmask_d;
      pend_q <= pend_d;
      sflag_q <= sflag_d;
      smask_q <= smask_d;
      swreq_q <= swreq_d;
      last_q <= last_d;
      pvec_q <= pvec_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      stk_q <= stk_d;
      st_q <= st_d;
      ack_q <= ack_d;
      fetch_q <= fetch_d;
      ackv_q <= ackv_d;
      nmi_busy_q <= nmi_busy_d;
      nmi_type_q <= nmi_type_d;
      nmi_prev_q <= nmi_pin_act;
      src_prev_q <= src_lvl;
    end
  end

  // bus state resets only on the bus reset, keeping handshakes coherent
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      ar_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 8'h00;
      ara_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      rd_q <= 32'h0000_0000;
      br_q <= `CIP_RESP_OKAY;
      rr_q <= `CIP_RESP_OKAY;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      ar_q <= ar_d;
      rv_q <= rv_d;
      awa_q <= awa_d;
      ara_q <= ara_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      rd_q <= rd_d;
      br_q <= br_d;
      rr_q <= rr_d;
    end
  end

  assign s_axi_awready = ~aw_q;
  assign s_axi_wready  = ~w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = ~ar_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign o_ack         = ack_q;
  assign o_ack_vector  = ackv_q;
  assign o_fetch       = fetch_q;
  assign o_pc          = pc_q;
  assign o_global_irq_disable = gid_q;
endmodule

//--- test/cip_src_model.sv
// partner: nmi pin, level-one sources and direct level lines of cip_top
// assumes tb commands it; pulses outlast the 3-flop input syncs
module cip_src_model (
  input  wire logic       clk,
  input  wire logic       nmi_inv,
  input  wire logic       nmi_go,
  input  wire logic [6:0] src_go,
  input  wire logic [5:0] lvl_go,
  output logic            nmi_pin,
  output logic [6:0]      src_irq,
  output logic [5:0]      lvl_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] n_q = 3'h0;
  logic [2:0] s_q = 3'h0;
  logic [6:0] act_q = 7'h00;
  logic [5:0] lvl_q = 6'h00;
  always @(posedge clk) begin
    n_q <= nmi_go ? 3'h5 : (n_q == 3'h0 ? 3'h0 : n_q - 3'h1);
    s_q <= (src_go != 7'h00) ? 3'h5 : (s_q == 3'h0 ? 3'h0 : s_q - 3'h1);
    if (src_go != 7'h00) act_q <= src_go;
    lvl_q <= lvl_go;
  end
  // idle level follows the polarity the bench programs
  assign nmi_pin = nmi_inv ^ (n_q != 3'h0);
  assign src_irq = (s_q != 3'h0) ? act_q : 7'h00;
  assign lvl_irq = lvl_q;
endmodule

//--- test/cip_top_sva.sv
// checker on cip_top ports: acknowledge, fetch, vectors, reset, bus holds
// assumes a bind from tb; one clock domain
module cip_top_sva
  import cip_pkg::*;
(
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        o_ack,
  input wire logic [5:0]  o_ack_vector,
  input wire logic        o_fetch,
  input wire logic [15:0] o_pc,
  input wire logic        o_global_irq_disable
);
  default clocking dc @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  sequence ack_then_fetch;
    o_ack ##1 (o_fetch && !o_ack);
  endsequence
  a_ack_fetch: assert property (o_ack |-> ack_then_fetch)
    else $error("no branch fetch after acknowledge");
  a_fetch_cause: assert property (o_fetch |-> $past(o_ack))
    else $error("fetch without acknowledge");
  a_ack_pc: assert property (o_ack |-> o_pc == {10'h000, o_ack_vector})
    else $error("pc not loaded with vector");
  a_vec_spacing: assert property (o_ack |-> !o_ack_vector[0])
    else $error("vector not on a two-word slot");
  a_nmi_disable: assert property (o_ack && o_ack_vector == 6'h24 |-> ##[0:1] o_global_irq_disable)
    else $error("nmi left maskables enabled");
  a_reset_state: assert property ($fell(I_RST) |-> o_global_irq_disable && !o_ack && o_pc == 16'h0000)
    else $error("state not cleared by reset");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

//--- test/tb.sv
// testbench: bus, nmi, software requests, levels, ranking, stack return
// assumes cip_pkg, cip_top, cip_src_model and cip_top_sva compiled first
`include "cip_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cip_pkg::*;
  logic        I_CORE_CLK = 1'b0;
  logic        I_RST = 1'b1;
  logic        i_ext_reset_pin_n = 1'b1;
  logic        i_power_on_reset_pin_n = 1'b1;
  logic        i_nmi_pin;
  logic [6:0]  i_src_irq;
  logic [5:0]  i_lvl_irq;
  logic        i_ret = 1'b0;
  logic [15:0] i_ret_pc = 16'h0000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_v, ack_cnt = 32'h0, seen = 32'h0;
  logic        o_ack, o_fetch, o_global_irq_disable, nmi_inv = 1'b0, nmi_go = 1'b0;
  logic [5:0]  o_ack_vector, lvl_go = 6'h00, last_vec = 6'h00;
  logic [15:0] o_pc, last_pc = 16'h0;
  logic [6:0]  src_go = 7'h00;
  int          err_total = 0;
  int          checks = 0;
  always #5 I_CORE_CLK = ~I_CORE_CLK;
  cip_src_model u_src (.clk(I_CORE_CLK), .nmi_inv(nmi_inv), .nmi_go(nmi_go), .src_go(src_go),
    .lvl_go(lvl_go), .nmi_pin(i_nmi_pin), .src_irq(i_src_irq), .lvl_irq(i_lvl_irq));
  cip_top DUT (.*);
  // ack is a one-cycle pulse that may land inside a bus wait, so log it here
  // sampled mid-cycle, away from the edge that launches it
  always @(negedge I_CORE_CLK) begin
    if (o_ack === 1'b1) begin
      ack_cnt <= ack_cnt + 32'h1;
      last_vec <= o_ack_vector;
      last_pc <= o_pc;
    end
  end
  task automatic complete_run();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("unexpected timeout at %0t got %h exp %h", $time, n, lim);
      complete_run();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_CORE_CLK);
  endtask
  // bready raised late on purpose so the slave must hold its answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic hs_a, hs_w, done;
    n = 0;
    done = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    while (n < 40 && !done) begin
      // settled values here are what the slave samples at the next edge
      @(negedge I_CORE_CLK);
      hs_a = s_axi_awvalid & (s_axi_awready === 1'b1);
      hs_w = s_axi_wvalid & (s_axi_wready === 1'b1);
      done = (s_axi_bvalid === 1'b1) & s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge I_CORE_CLK);
      n++;
      if (hs_a) s_axi_awvalid <= 1'b0;
      if (hs_w) s_axi_wvalid <= 1'b0;
      if (n == 3) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    guard(done ? 0 : n, 40);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic hs_a, done;
    n = 0;
    done = 1'b0;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    while (n < 40 && !done) begin
      @(negedge I_CORE_CLK);
      hs_a = s_axi_arvalid & (s_axi_arready === 1'b1);
      done = (s_axi_rvalid === 1'b1) & s_axi_rready;
      rd_v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge I_CORE_CLK);
      n++;
      if (hs_a) s_axi_arvalid <= 1'b0;
      if (n == 3) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    guard(done ? 0 : n, 40);
  endtask
  task automatic gid_is(input logic b);
    axi_rd(`CIP_ADDR_STATUS0);
    chk({31'h0, rd_v[`CIP_GID_BIT]}, {31'h0, b});
  endtask
  task automatic wait_ack(input logic [5:0] v);
    int n;
    n = 0;
    while (ack_cnt == seen && n < 30) begin
      tick(1);
      n++;
    end
    guard(n, 30);
    seen = ack_cnt;
    chk({26'h0, last_vec}, {26'h0, v});
    chk({16'h0, last_pc}, {26'h0, v});
  endtask
  task automatic no_ack();
    tick(12);
    chk(ack_cnt, seen);
  endtask
  task automatic pulse(input logic n, input logic r, input logic [6:0] s);
    nmi_go <= n;
    i_ret <= r;
    src_go <= s;
    tick(1);
    nmi_go <= 1'b0;
    i_ret <= 1'b0;
    src_go <= 7'h00;
    tick(6);
  endtask
  task automatic s_reset();
    gid_is(1'b1);
    axi_rd(`CIP_ADDR_LVL_MASK);
    chk(rd_v, 32'h0);
    axi_rd(`CIP_ADDR_PEND);
    chk(rd_v, 32'h0);
    axi_rd(8'h3C);
    chk({30'h0, rsp}, {30'h0, `CIP_RESP_SLVERR});
  endtask
  task automatic s_nmi();
    pulse(1'b1, 1'b0, 7'h00);
    wait_ack(`CIP_VEC_NMI);
    pulse(1'b1, 1'b0, 7'h00);
    no_ack();
    pulse(1'b0, 1'b1, 7'h00);
    axi_wr(`CIP_ADDR_STATUS0, 32'h0);
    pulse(1'b1, 1'b0, 7'h00);
    wait_ack(`CIP_VEC_NMI);
    gid_is(1'b1);
    nmi_inv <= 1'b1;
    axi_wr(`CIP_ADDR_CTRL, 32'h1);
    pulse(1'b0, 1'b1, 7'h00);
    pulse(1'b1, 1'b0, 7'h00);
    wait_ack(`CIP_VEC_NMI);
  endtask
  task automatic s_sw();
    logic [4:0] ks [3];
    ks = '{5'd7, 5'd17, 5'd31};
    pulse(1'b0, 1'b1, 7'h00);
    axi_wr(`CIP_ADDR_STATUS0, 32'h0);
    axi_wr(`CIP_ADDR_SW_REQ, 32'h4000_0000);
    wait_ack(`CIP_VEC_TRAP);
    gid_is(1'b0);
    foreach (ks[i]) begin
      axi_wr(`CIP_ADDR_STATUS0, 32'h0);
      axi_wr(`CIP_ADDR_SW_REQ, 32'h8000_0000 | {27'h0, ks[i]});
      wait_ack({ks[i], 1'b0});
      gid_is(1'b1);
    end
  endtask
  task automatic s_level();
    axi_wr(`CIP_ADDR_SRC_MASK, 32'h08);
    axi_wr(`CIP_ADDR_LVL_MASK, 32'h0);
    axi_wr(`CIP_ADDR_STATUS0, 32'h0);
    pulse(1'b0, 1'b0, 7'h04);
    axi_rd(`CIP_ADDR_SRC_FLAG);
    chk(rd_v, 32'h04);
    axi_rd(`CIP_ADDR_PEND);
    chk(rd_v, 32'h0);
    pulse(1'b0, 1'b0, 7'h08);
    axi_rd(`CIP_ADDR_PEND);
    chk(rd_v, 32'h1);
    no_ack();
    axi_wr(`CIP_ADDR_LVL_MASK, 32'h1);
    wait_ack(6'h02);
    gid_is(1'b1);
    axi_rd(`CIP_ADDR_PERIPH_VEC);
    chk(rd_v, 32'h4);
    axi_wr(`CIP_ADDR_SRC_FLAG, 32'h0C);
    axi_rd(`CIP_ADDR_PEND);
    chk(rd_v, 32'h0);
    axi_rd(`CIP_ADDR_PERIPH_VEC);
    chk(rd_v, 32'h0);
    // real ack leaves offset 4, then a withdrawn source must give phantom
    pulse(1'b0, 1'b0, 7'h08);
    axi_wr(`CIP_ADDR_STATUS0, 32'h0);
    wait_ack(6'h02);
    pulse(1'b0, 1'b0, 7'h08);
    axi_wr(`CIP_ADDR_SRC_FLAG, 32'h08);
    axi_wr(`CIP_ADDR_STATUS0, 32'h0);
    wait_ack(6'h02);
    axi_rd(`CIP_ADDR_PERIPH_VEC);
    chk(rd_v, 32'h0);
  endtask
  task automatic s_rank();
    axi_wr(`CIP_ADDR_LVL_MASK, 32'h3F);
    lvl_go <= 6'h06;
    tick(6);
    lvl_go <= 6'h00;
    // let the level lines fall first, or level two pends again
    tick(6);
    axi_wr(`CIP_ADDR_STATUS0, 32'h0);
    wait_ack(6'h04);
    axi_wr(`CIP_ADDR_STATUS0, 32'h0);
    wait_ack(6'h06);
  endtask
  task automatic s_return();
    I_RST <= 1'b1;
    // polarity control resets to active high, so the pin must idle low
    nmi_inv <= 1'b0;
    tick(3);
    I_RST <= 1'b0;
    tick(4);
    axi_wr(`CIP_ADDR_SW_REQ, 32'h4000_0000);
    wait_ack(`CIP_VEC_TRAP);
    i_ret_pc <= 16'h1234;
    axi_wr(`CIP_ADDR_SW_REQ, 32'h4000_0000);
    wait_ack(`CIP_VEC_TRAP);
    axi_rd(`CIP_ADDR_STACK_TOP);
    chk(rd_v, 32'h1234);
    pulse(1'b0, 1'b1, 7'h00);
    chk({16'h0, o_pc}, 32'h1234);
    axi_wr(`CIP_ADDR_LVL_MASK, 32'h3F);
    i_ext_reset_pin_n <= 1'b0;
    tick(4);
    i_ext_reset_pin_n <= 1'b1;
    tick(6);
    axi_rd(`CIP_ADDR_LVL_MASK);
    chk(rd_v, 32'h0);
    gid_is(1'b1);
  endtask
  initial begin
    tick(3);
    I_RST <= 1'b0;
    tick(4);
    s_reset();
    s_nmi();
    s_sw();
    s_level();
    s_rank();
    s_return();
    complete_run();
  end
endmodule
bind cip_top cip_top_sva u_sva (.*);
